/* File: design/msc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module msc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule : msc_sync

/* File: design/msc_top.sv */
// Module-side sideband control: reset decode, interrupt, link speed
// What this block does
// - Management over two-wire open-drain SCL/SDA link
// - Fast-mode 400 kbit/s always supported
// - Fast-mode Plus and I3C SDR always advertised as well
// - Shared line low level is module reset
// - Module interrupt high internally, low at host
// - In reset, no interrupt reaches the host
// - Normal idle: reset high, host interrupt high
// - Interrupt only asserted while out of reset
// - Reset overrides all, low power, transmitters off
// - Force-low-power bit reverts to default on reset
`timescale 1ns/10ps
`include "msc_defs.svh"
module msc_top (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic SHARED_IRQ_RESET_LINE,
  input wire logic LOW_POWER_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT_REQ,
  input wire logic IRQ_REQ,
  input wire logic FLP_WR,
  input wire logic FLP_WDATA,
  input wire logic [1:0] SPEED_SEL,
  output logic SCL_OUT,
  output logic SCL_OE,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic MODULE_IRQ_DRIVE,
  output logic MODULE_RESET_N,
  output logic FORCE_LOW_POWER_BIT,
  output logic LOW_POWER_MODE,
  output logic TX_ENABLE,
  output logic [`MSC_CAP_W-1:0] SPEED_CAP,
  output logic [1:0] SPEED_ACTIVE,
  output logic SCL_RISE,
  output logic SCL_S,
  output logic SDA_S
);
  typedef struct packed {
    logic [`MSC_CNT_W-1:0] cnt;
    logic filt;
    logic rst_n;
    logic scl_prev;
    logic flp;
    logic irq;
    logic [1:0] spd;
    msc_pkg::msc_state_e st;
  } msc_state_s;

  msc_state_s cur_ff;
  msc_state_s nxt_ff;
  msc_pkg::msc_pins_s pins_s;
  msc_pkg::msc_drv_s drv;

  // Capability advertised to the host; FM is always present
  localparam logic [`MSC_CAP_W-1:0] CAP =
    `MSC_CAP_W'(1 << `MSC_CAP_FM_BIT) |
    `MSC_CAP_W'(1 << `MSC_CAP_FMP_BIT) |
    `MSC_CAP_W'(1 << `MSC_CAP_SDR_BIT);
  localparam logic [`MSC_CNT_W-1:0] DEG =
    `MSC_CNT_W'(`MSC_RST_DEGLITCH_CYC);

  // Power-on contents of the state register
  localparam msc_state_s RST_VAL = '{
    cnt: '0,
    filt: 1'b0,
    rst_n: 1'b0,
    scl_prev: 1'b1,
    flp: `MSC_FLP_DEFAULT,
    irq: 1'b0,
    spd: `MSC_SPD_SM,
    st: msc_pkg::MSC_IN_RESET
  };

  function automatic logic spd_ok(input logic [1:0] s,
                                  input logic [`MSC_CAP_W-1:0] c);
    case (s)
      `MSC_SPD_SM: spd_ok = 1'b1;
      `MSC_SPD_FM: spd_ok = c[`MSC_CAP_FM_BIT];
      `MSC_SPD_FMP: spd_ok = c[`MSC_CAP_FMP_BIT];
      `MSC_SPD_SDR: spd_ok = c[`MSC_CAP_SDR_BIT];
      default: spd_ok = 1'b0;
    endcase
  endfunction : spd_ok

  // TX_ENABLE runs only in the active power state; SDA_OE is gated by reset, not power state
  function automatic logic is_active(input msc_pkg::msc_state_e s);
    is_active = s == msc_pkg::MSC_ACTIVE;
  endfunction : is_active

  // Every pin passes two flops before use
  msc_sync u_rst (
    .clk(CLOCK),
    .rst_n(NRST),
    .d(SHARED_IRQ_RESET_LINE),
    .q(pins_s.shared_irq_reset_line)
  );
  msc_sync u_lp (
    .clk(CLOCK),
    .rst_n(NRST),
    .d(LOW_POWER_N),
    .q(pins_s.low_power_n)
  );
  msc_sync u_scl (
    .clk(CLOCK),
    .rst_n(NRST),
    .d(SCL_IN),
    .q(pins_s.scl_in)
  );
  msc_sync u_sda (
    .clk(CLOCK),
    .rst_n(NRST),
    .d(SDA_IN),
    .q(pins_s.sda_in)
  );

  always_comb begin
    nxt_ff = cur_ff;
    // Deglitch: level must hold DEG cycles before it is accepted
    if (pins_s.shared_irq_reset_line == cur_ff.filt) begin
      nxt_ff.cnt = '0;
    end else if (cur_ff.cnt >= DEG - `MSC_CNT_W'(1)) begin
      nxt_ff.cnt = '0;
      nxt_ff.filt = pins_s.shared_irq_reset_line;
    end else begin
      nxt_ff.cnt = cur_ff.cnt + `MSC_CNT_W'(1);
    end

    // Assert fast on filtered low, release one cycle later
    nxt_ff.rst_n = cur_ff.filt && nxt_ff.filt;
    nxt_ff.scl_prev = pins_s.scl_in;

    // Held state returns to defaults during reset
    if (!cur_ff.rst_n) begin
      nxt_ff.flp = `MSC_FLP_DEFAULT;
      nxt_ff.irq = 1'b0;
      nxt_ff.spd = `MSC_SPD_SM;
      nxt_ff.st = msc_pkg::MSC_IN_RESET;
    end else begin
      if (FLP_WR) begin
        nxt_ff.flp = FLP_WDATA;
      end
      nxt_ff.irq = IRQ_REQ;
      if (spd_ok(SPEED_SEL, CAP)) begin
        nxt_ff.spd = SPEED_SEL;
      end

      // Power state: low power until pin and bit allow
      case (cur_ff.st)
        msc_pkg::MSC_IN_RESET: nxt_ff.st = msc_pkg::MSC_LOW_POWER;
        msc_pkg::MSC_LOW_POWER: begin
          if (pins_s.low_power_n && !nxt_ff.flp) begin
            nxt_ff.st = msc_pkg::MSC_ACTIVE;
          end
        end
        msc_pkg::MSC_ACTIVE: begin
          if (!pins_s.low_power_n || nxt_ff.flp) begin
            nxt_ff.st = msc_pkg::MSC_LOW_POWER;
          end
        end
        default: nxt_ff.st = msc_pkg::MSC_IN_RESET;
      endcase
    end

    // Internal reset wins over interrupt and power state in the same cycle
    if (!nxt_ff.rst_n) begin
      nxt_ff.irq = 1'b0;
      nxt_ff.st = msc_pkg::MSC_IN_RESET;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cur_ff <= RST_VAL;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Open-drain: only pull low, slave never drives SCL
  assign drv.scl_oe = 1'b0;
  assign drv.sda_oe = SDA_OUT_REQ && cur_ff.rst_n;
  assign SCL_OUT = 1'b0;
  assign SCL_OE = drv.scl_oe;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = drv.sda_oe;

  // Shared line: interrupt and reset
  assign MODULE_IRQ_DRIVE = cur_ff.irq && cur_ff.rst_n;
  assign MODULE_RESET_N = cur_ff.rst_n;

  // Power state
  assign FORCE_LOW_POWER_BIT = cur_ff.flp;
  assign LOW_POWER_MODE = !is_active(cur_ff.st);
  assign TX_ENABLE = is_active(cur_ff.st);

  // Link speed
  assign SPEED_CAP = CAP;
  assign SPEED_ACTIVE = cur_ff.spd;

  // Synchronised link levels and clock edge
  assign SCL_RISE = pins_s.scl_in && !cur_ff.scl_prev;
  assign SCL_S = pins_s.scl_in;
  assign SDA_S = pins_s.sda_in;
endmodule : msc_top

/* File: include/msc_defs.svh */
// Timing and reset constants for the module sideband control block
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_CLK_HZ 10000000
`define MSC_RST_DEGLITCH_NS 1000
`define MSC_RST_DEGLITCH_CYC ((`MSC_RST_DEGLITCH_NS * (`MSC_CLK_HZ / 1000)) / 1000000)
`define MSC_CNT_W 4
`define MSC_SPD_SM 2'h0
`define MSC_SPD_FM 2'h1
`define MSC_SPD_FMP 2'h2
`define MSC_SPD_SDR 2'h3
`define MSC_CAP_W 3
`define MSC_CAP_FMP_BIT 0
`define MSC_CAP_SDR_BIT 1
`define MSC_CAP_FM_BIT 2
`define MSC_FLP_DEFAULT 1'b0
`endif

/* File: include/msc_pkg.sv */
// Types for the module sideband control block
package msc_pkg;
  typedef enum logic [1:0] {MSC_IN_RESET, MSC_LOW_POWER, MSC_ACTIVE} msc_state_e;
  typedef struct packed {
    logic scl_in;
    logic sda_in;
    logic shared_irq_reset_line;
    logic low_power_n;
  } msc_pins_s;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } msc_drv_s;
endpackage : msc_pkg

/* File: verification/msc_host_model.sv */
// Host side: shared line, link clock, open-drain data
`timescale 1ns/10ps
module msc_host_model (
  input wire logic host_reset_drive_n,
  input wire logic frame,
  input wire logic sda_pull,
  input wire logic irq_drive,
  input wire logic sda_oe,
  output logic shared_irq_reset_line,
  output logic host_side_irq_n,
  output logic scl,
  output logic sda
);
  assign shared_irq_reset_line = host_reset_drive_n;
  // Low line (reset or no module) reads as no interrupt
  assign host_side_irq_n = !(host_reset_drive_n && irq_drive);
  assign sda = !(sda_pull || sda_oe);
  initial begin
    scl = 1'h1;
    #17;
    forever #400 scl = frame ? !scl : 1'h1;
  end
endmodule : msc_host_model

/* File: verification/msc_top_props.sv */
// Checker on the sideband control top ports
`timescale 1ns/10ps
module msc_top_props (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic SHARED_IRQ_RESET_LINE,
  input wire logic SDA_OUT_REQ,
  input wire logic IRQ_REQ,
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  input wire logic MODULE_IRQ_DRIVE,
  input wire logic MODULE_RESET_N,
  input wire logic FORCE_LOW_POWER_BIT,
  input wire logic TX_ENABLE,
  input wire logic [1:0] SPEED_ACTIVE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  sequence s_irq;
    MODULE_RESET_N && IRQ_REQ ##1 MODULE_RESET_N;
  endsequence
  sequence s_low;
    $fell(SHARED_IRQ_RESET_LINE) ##1 !SHARED_IRQ_RESET_LINE [*8]
      ##1 !SHARED_IRQ_RESET_LINE [*7];
  endsequence
  chk_irq_gated: assert property (!MODULE_RESET_N |-> !MODULE_IRQ_DRIVE)
    else $error("irq in reset");
  chk_irq_follow: assert property (s_irq |-> MODULE_IRQ_DRIVE)
    else $error("irq lost");
  chk_rst_glitch: assert property ($fell(MODULE_RESET_N) |->
    $past(SHARED_IRQ_RESET_LINE, 11) == 1'h0) else $error("early reset");
  chk_rst_taken: assert property (s_low |-> ##1 !MODULE_RESET_N)
    else $error("reset missed");
  chk_rst_quiet: assert property (!MODULE_RESET_N [*2] |-> !TX_ENABLE &&
    SPEED_ACTIVE == 2'h0 && !FORCE_LOW_POWER_BIT) else $error("reset leak");
  chk_tx_flp: assert property (TX_ENABLE |-> !FORCE_LOW_POWER_BIT)
    else $error("tx with flp");
  chk_sda_gate: assert property (SDA_OE == (SDA_OUT_REQ && MODULE_RESET_N))
    else $error("sda drive");
  chk_scl_idle: assert property (!SCL_OE)
    else $error("scl driven");
endmodule : msc_top_props
bind msc_top msc_top_props u_props (.CLOCK, .NRST, .SHARED_IRQ_RESET_LINE,
  .SDA_OUT_REQ, .IRQ_REQ, .SCL_OE, .SDA_OE, .MODULE_IRQ_DRIVE,
  .MODULE_RESET_N, .FORCE_LOW_POWER_BIT, .TX_ENABLE, .SPEED_ACTIVE);

/* File: verification/testbench.sv */
// Bench for the sideband control block
`timescale 1ns/10ps
module testbench;
  logic CLOCK = 0, NRST = 0, host_rst_n = 1, frame = 0, pull = 0;
  logic LOW_POWER_N = 1, SDA_OUT_REQ = 0, IRQ_REQ = 0, FLP_WR = 0;
  logic FLP_WDATA = 0, SHARED_IRQ_RESET_LINE, SCL_IN, SDA_IN, SDA_OE;
  logic MODULE_IRQ_DRIVE, MODULE_RESET_N, FORCE_LOW_POWER_BIT, TX_ENABLE;
  logic hirq_n;
  logic SCL_OUT, SDA_OUT, LOW_POWER_MODE, SCL_RISE, SCL_S, SDA_S;
  int pin_rises = 0, rise_seen = 0;
  logic [1:0] SPEED_SEL = 2'h0, SPEED_ACTIVE;
  logic [2:0] SPEED_CAP;
  int bad_count = 0, checks_done = 0, cycles = 0;
  always #50 CLOCK = !CLOCK;
  always @(posedge SCL_IN) pin_rises++;
  always @(negedge CLOCK) if (SCL_RISE === 1'b1) rise_seen++;
  msc_host_model host (.host_reset_drive_n(host_rst_n), .frame,
    .sda_pull(pull), .irq_drive(MODULE_IRQ_DRIVE), .sda_oe(SDA_OE),
    .shared_irq_reset_line(SHARED_IRQ_RESET_LINE),
    .host_side_irq_n(hirq_n), .scl(SCL_IN), .sda(SDA_IN));
  msc_top DUT (.CLOCK, .NRST, .SHARED_IRQ_RESET_LINE, .LOW_POWER_N, .SCL_IN,
    .SDA_IN, .SDA_OUT_REQ, .IRQ_REQ, .FLP_WR, .FLP_WDATA, .SPEED_SEL,
    .SCL_OUT, .SCL_OE(), .SDA_OUT, .SDA_OE, .MODULE_IRQ_DRIVE,
    .MODULE_RESET_N, .FORCE_LOW_POWER_BIT, .LOW_POWER_MODE, .TX_ENABLE,
    .SPEED_CAP, .SPEED_ACTIVE, .SCL_RISE, .SCL_S, .SDA_S);
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic t_link;
    pin_rises = 0;
    rise_seen = 0;
    frame = 1;
    SDA_OUT_REQ = 1;
    cyc(2);
    chk({SDA_OE, SDA_IN}, 3'h2);
    SDA_OUT_REQ = 0;
    pull = 1;
    cyc(20);
    chk({SDA_OE, SDA_IN}, 3'h0);
    pull = 0;
    frame = 0;
    cyc(12);
    chk(pin_rises != 0, 3'h1);
    chk(rise_seen[2:0], pin_rises[2:0]);
    chk({SCL_OUT, SDA_OUT, SCL_S}, 3'h1);
    chk(SDA_S, 3'h1);
    $display("link test done");
  endtask : t_link
  task automatic t_irq;
    IRQ_REQ = 1;
    cyc(2);
    chk({MODULE_IRQ_DRIVE, hirq_n, MODULE_RESET_N}, 3'h5);
    IRQ_REQ = 0;
    cyc(2);
    chk(hirq_n, 3'h1);
    $display("irq test done");
  endtask : t_irq
  task automatic t_flp_speed;
    FLP_WR = 1;
    FLP_WDATA = 1;
    cyc(1);
    FLP_WR = 0;
    cyc(2);
    chk({FORCE_LOW_POWER_BIT, TX_ENABLE}, 3'h2);
    chk(LOW_POWER_MODE, 3'h1);
    FLP_WR = 1;
    FLP_WDATA = 0;
    cyc(1);
    FLP_WR = 0;
    cyc(2);
    chk({FORCE_LOW_POWER_BIT, TX_ENABLE, LOW_POWER_MODE}, 3'h2);
    chk(SPEED_CAP, 3'h7);
    for (int s = 0; s < 4; s++) begin
      SPEED_SEL = s[1:0];
      cyc(2);
      chk(SPEED_ACTIVE, s[2:0]);
    end
    $display("flp speed test done");
  endtask : t_flp_speed
  task automatic t_reset;
    host_rst_n = 0;
    cyc(5);
    host_rst_n = 1;
    cyc(3);
    chk(MODULE_RESET_N, 3'h1);
    host_rst_n = 0;
    cyc(20);
    IRQ_REQ = 1;
    cyc(3);
    chk({MODULE_RESET_N, TX_ENABLE, hirq_n}, 3'h1);
    chk({FORCE_LOW_POWER_BIT, SPEED_ACTIVE}, 3'h0);
    chk({MODULE_IRQ_DRIVE, LOW_POWER_MODE}, 3'h1);
    host_rst_n = 1;
    IRQ_REQ = 0;
    cyc(20);
    chk({MODULE_RESET_N, hirq_n, TX_ENABLE}, 3'h7);
    $display("reset test done");
  endtask : t_reset
  always @(posedge CLOCK) if (++cycles == 3000) begin
    bad_count++;
    stop_test;
  end
  initial begin
    cyc(16);
    NRST = 1;
    cyc(20);
    t_link;
    t_irq;
    t_flp_speed;
    t_reset;
    stop_test;
  end
endmodule : testbench
